// File: core/rcm_pkg.sv
// Constants, types and the mode decode for the chip mode and pin controller.
// Assumes an APB master in the same clock domain and radio blocks that obey the enables.
//
// Summary of operation
// - Standby keeps serial port, reset, regulators and crystal on; clock out if enabled.
// - Synthesizer mode adds VCO regulator and all PLL and LO blocks to standby.
// - Receive adds receive chain, signal strength, demodulator, bit sync and receive features.
// - Transmit adds waveform generator, filters, mixers, amplifier driver, amplifier, choke supply.
// - Sleep keeps only serial port and reset; event, clock and lock pins float.
// - Selects and serial inputs always inputs; clock output driven except in sleep.
// - Serial output driven only while a select is low, else high impedance.
// - With both selects low the configuration interface wins.
// - Event lines float in sleep; standby/synth drive unless continuous; rx/tx always drive.
// - Outside sleep the lock pin is driven only when lock_pin_enable is set.
// - The data pin is an output only in receive mode.
// - Event lines signal with configured level, only when enabled and unmasked.
// - Continuous mode passes demodulated data on the pin; FIFO path stays idle.
// - Buffered and packet modes move data through the FIFO, not the pin.
// - Baseband tone frequency equals the eight-bit deviation_value from deviation_reg.
// - FSK: data 1 gives +90 degree phase, data 0 gives -90 degrees.
// - OOK: phase constant; amplifier on for 1, off for 0; its choke supply enable stays on.
// - Configuration writes take effect on the rising edge of config_select_n.
// - Configuration values are kept while in sleep.
// - lock_status_flag stays set until the host writes one to it.
package rcm_pkg;

    localparam int          RCM_AW        = 8;
    localparam logic [7:0]  RCM_GEN_ADDR  = 8'h00;
    localparam logic [7:0]  RCM_CLK_ADDR  = 8'h04;
    localparam logic [7:0]  RCM_DEV_ADDR  = 8'h08;
    localparam logic [7:0]  RCM_LOCK_ADDR = 8'h0c;
    localparam logic [7:0]  RCM_EVT_ADDR  = 8'h10;
    localparam logic [7:0]  RCM_STAT_ADDR = 8'h14;
    localparam int          RCM_MODE_LSB  = 5;
    localparam int          RCM_OOK_BIT   = 4;
    localparam int          RCM_CONT_BIT  = 2;
    localparam int          RCM_CLKEN_BIT = 0;
    localparam int          RCM_LKEN_BIT  = 0;
    localparam int          RCM_LKST_BIT  = 1;
    localparam int          RCM_EN_LSB    = 0;
    localparam int          RCM_UNM_LSB   = 2;
    localparam int          RCM_POL_LSB   = 4;
    localparam logic [7:0]  RCM_GEN_RST   = 8'h20;
    localparam logic [7:0]  RCM_CLK_RST   = 8'h01;
    localparam logic [7:0]  RCM_DEV_RST   = 8'h00;
    localparam logic [5:0]  RCM_EVT_RST   = 6'h00;

    typedef enum logic [2:0] {
        RCM_SLEEP = 3'b000,
        RCM_STBY  = 3'b001,
        RCM_SYNTH = 3'b010,
        RCM_RX    = 3'b011,
        RCM_TX    = 3'b100
    } rcm_mode_e;

    typedef struct packed {
        logic spi, por, reg_top, reg_dig, xo;
        logic vco_reg, pll_lo;
        logic rx_chain, rssi, demod, bitsync, rx_dig;
        logic dds, interp, upmix, pa_drv, pa, amp_choke_supply;
    } rcm_blk_en_s;

    // Block enables per mode; reserved codes fall back to the sleep set.
    function automatic rcm_blk_en_s rcm_blocks(input logic [2:0] m);
        rcm_blk_en_s b;
        b = '0;
        b.spi = 1'b1;
        b.por = 1'b1;
        unique case (m)
            RCM_SLEEP: ;
            RCM_STBY, RCM_SYNTH, RCM_RX, RCM_TX: begin
                {b.reg_top, b.reg_dig, b.xo} = 3'h7;
                if (m != RCM_STBY) {b.vco_reg, b.pll_lo} = 2'h3;
                if (m == RCM_RX) {b.rx_chain, b.rssi, b.demod, b.bitsync, b.rx_dig} = 5'h1f;
                if (m == RCM_TX) {b.dds, b.interp, b.upmix, b.pa_drv, b.pa,
                                  b.amp_choke_supply} = 6'h3f;
            end
            default: ;
        endcase
        return b;
    endfunction : rcm_blocks

endpackage : rcm_pkg

// File: core/rcm_mode_ctrl.sv
// Chip mode controller: staged configuration, block enables, pin directions, TX bit mapping.
// Assumes all pins are synchronous to CLK_IN and an APB master on the same clock.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module rcm_mode_ctrl
    import rcm_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK_IN,
    input  wire logic              SRST_IN,
    // APB slave
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [RCM_AW-1:0] PADDR_IN,
    input  wire logic [31:0]       PWDATA_IN,
    output logic      [31:0]       PRDATA_OUT,
    output logic                   PREADY_OUT,
    output logic                   PSLVERR_OUT,
    // Serial port selects and output
    input  wire logic              CFG_SEL_N_IN,
    input  wire logic              DAT_SEL_N_IN,
    input  wire logic              SO_CFG_IN,
    input  wire logic              SO_DAT_IN,
    output logic                   SDO_OUT,
    output logic                   SDO_OE_N_OUT,
    output logic                   CFG_ACT_OUT,
    output logic                   DAT_ACT_OUT,
    // Event lines
    input  wire logic [1:0]        EVT_SRC_IN,
    output logic                   EVT0_OUT,
    output logic                   EVT0_OE_N_OUT,
    output logic                   EVT1_OUT,
    output logic                   EVT1_OE_N_OUT,
    // Data pin and transmit bit sources
    input  wire logic              DATA_IN,
    input  wire logic              DEMOD_IN,
    input  wire logic              TX_SR_BIT_IN,
    output logic                   DATA_OUT,
    output logic                   DATA_OE_N_OUT,
    // Host clock and lock pins
    input  wire logic              HCLK_SRC_IN,
    input  wire logic              PLL_LOCK_IN,
    output logic                   HCLK_OUT,
    output logic                   HCLK_OE_N_OUT,
    output logic                   LOCK_OUT,
    output logic                   LOCK_OE_N_OUT,
    // Radio controls
    output rcm_blk_en_s            BLK_EN_OUT,
    output logic      [7:0]        TONE_DEV_OUT,
    output logic                   IQ_PHASE_POS_OUT,
    output logic                   PA_ON_OUT,
    output logic                   FIFO_PATH_EN_OUT
);

    // Staged (software view) and active configuration.
    logic [7:0] gen_s_q, gen_q, dev_s_q, dev_q;
    logic       clk_s_q, clk_q, lken_s_q, lken_q;
    logic [5:0] evt_s_q, evt_q;
    logic       lock_sts_q, cfg_prev_q;
    logic [31:0] rdata_q;
    logic       ready_q, err_q;

    // Registered pin and radio outputs.
    logic sdo_q, sdo_oe_n_q, cfg_act_q, dat_act_q;
    logic evt0_q, evt0_oe_n_q, evt1_q, evt1_oe_n_q;
    logic data_q, data_oe_n_q, hclk_q, hclk_oe_n_q, lock_q, lock_oe_n_q;
    logic iq_pos_q, pa_on_q, fifo_en_q;
    logic [7:0] tone_q;
    rcm_blk_en_s blk_q;

    // APB decode.
    wire        apb_acc   = PSEL_IN && PENABLE_IN && !ready_q;
    wire        apb_done  = PSEL_IN && PENABLE_IN && ready_q;
    wire        apb_wr    = apb_done && PWRITE_IN;
    wire        hit_gen   = PADDR_IN == RCM_GEN_ADDR;
    wire        hit_clk   = PADDR_IN == RCM_CLK_ADDR;
    wire        hit_dev   = PADDR_IN == RCM_DEV_ADDR;
    wire        hit_lock  = PADDR_IN == RCM_LOCK_ADDR;
    wire        hit_evt   = PADDR_IN == RCM_EVT_ADDR;
    wire        hit_stat  = PADDR_IN == RCM_STAT_ADDR;
    wire        hit_any   = hit_gen | hit_clk | hit_dev | hit_lock | hit_evt | hit_stat;
    wire        lock_clr  = apb_wr && hit_lock && PWDATA_IN[RCM_LKST_BIT];
    wire [31:0] rd_mux    =
        hit_gen  ? {24'h0, gen_s_q} :
        hit_clk  ? {31'h0, clk_s_q} :
        hit_dev  ? {24'h0, dev_s_q} :
        hit_lock ? {30'h0, lock_sts_q, lken_s_q} :
        hit_evt  ? {26'h0, evt_s_q} :
        hit_stat ? {11'h0, blk_q, gen_q[RCM_MODE_LSB+:3]} : 32'h0;

    // Active mode view and commit decode.
    wire [2:0]  mode_raw  = gen_q[RCM_MODE_LSB+:3];
    rcm_mode_e  mode;
    assign mode = rcm_mode_e'(mode_raw);
    wire        cont      = gen_q[RCM_CONT_BIT];
    wire        ook       = gen_q[RCM_OOK_BIT];
    wire        cfg_rise  = !cfg_prev_q && CFG_SEL_N_IN;
    wire [2:0]  mode_new  = gen_s_q[RCM_MODE_LSB+:3];
    wire        mode_rsv  = mode_new > RCM_TX;
    wire [7:0]  gen_cmt   = mode_rsv ? {mode_raw, gen_s_q[4:0]} : gen_s_q;

    // Pin direction and level decode.
    wire        asleep    = mode == RCM_SLEEP;
    wire        evt_drv   = (mode == RCM_RX) || (mode == RCM_TX) ||
                            (((mode == RCM_STBY) || (mode == RCM_SYNTH)) && !cont);
    wire [1:0]  evt_act   = EVT_SRC_IN & evt_q[RCM_EN_LSB+:2] & evt_q[RCM_UNM_LSB+:2];
    wire [1:0]  evt_lvl   = ~(evt_act ^ evt_q[RCM_POL_LSB+:2]);
    wire        sel_cfg   = !CFG_SEL_N_IN;
    wire        sel_dat   = CFG_SEL_N_IN && !DAT_SEL_N_IN;
    wire        tx_bit    = cont ? DATA_IN : TX_SR_BIT_IN;
    wire        in_tx     = mode == RCM_TX;

    // APB slave: one wait state, write and read data at the edge that sees PREADY high.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ready_q <= apb_acc;
            err_q   <= apb_acc && !hit_any;
            rdata_q <= (apb_acc && !PWRITE_IN) ? rd_mux : 32'h0;
        end
    end

    // Staged configuration, kept through sleep and reset only by SRST_IN.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            gen_s_q  <= RCM_GEN_RST;
            clk_s_q  <= RCM_CLK_RST[RCM_CLKEN_BIT];
            dev_s_q  <= RCM_DEV_RST;
            lken_s_q <= 1'b0;
            evt_s_q  <= RCM_EVT_RST;
        end else if (apb_wr) begin
            if (hit_gen)  gen_s_q  <= PWDATA_IN[7:0];
            if (hit_clk)  clk_s_q  <= PWDATA_IN[RCM_CLKEN_BIT];
            if (hit_dev)  dev_s_q  <= PWDATA_IN[7:0];
            if (hit_lock) lken_s_q <= PWDATA_IN[RCM_LKEN_BIT];
            if (hit_evt)  evt_s_q  <= PWDATA_IN[5:0];
        end
    end

    // Active configuration loads only when the configuration select is released.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            cfg_prev_q <= 1'b1;
            gen_q      <= RCM_GEN_RST;
            clk_q      <= RCM_CLK_RST[RCM_CLKEN_BIT];
            dev_q      <= RCM_DEV_RST;
            lken_q     <= 1'b0;
            evt_q      <= RCM_EVT_RST;
        end else begin
            cfg_prev_q <= CFG_SEL_N_IN;
            if (cfg_rise) begin
                gen_q  <= gen_cmt;
                clk_q  <= clk_s_q;
                dev_q  <= dev_s_q;
                lken_q <= lken_s_q;
                evt_q  <= evt_s_q;
            end
        end
    end

    // Lock flag: hardware set wins over a write-one clear in the same cycle.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) lock_sts_q <= 1'b0;
        else         lock_sts_q <= PLL_LOCK_IN || (lock_sts_q && !lock_clr);
    end

    // Serial output and select priority.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            sdo_q      <= 1'b0;
            sdo_oe_n_q <= 1'b1;
            cfg_act_q  <= 1'b0;
            dat_act_q  <= 1'b0;
        end else begin
            sdo_oe_n_q <= !(sel_cfg || sel_dat);
            sdo_q      <= sel_cfg ? SO_CFG_IN : SO_DAT_IN;
            cfg_act_q  <= sel_cfg;
            dat_act_q  <= sel_dat;
        end
    end

    // Mode-dependent pins.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            {evt0_q, evt1_q}           <= 2'h0;
            {evt0_oe_n_q, evt1_oe_n_q} <= 2'h3;
            data_q      <= 1'b0;
            data_oe_n_q <= 1'b1;
            hclk_q      <= 1'b0;
            hclk_oe_n_q <= 1'b1;
            lock_q      <= 1'b0;
            lock_oe_n_q <= 1'b1;
        end else begin
            evt0_oe_n_q <= !evt_drv;
            evt1_oe_n_q <= !evt_drv;
            evt0_q      <= evt_lvl[0];
            evt1_q      <= evt_lvl[1];
            data_oe_n_q <= mode != RCM_RX;
            data_q      <= cont && DEMOD_IN;
            hclk_oe_n_q <= asleep;
            hclk_q      <= HCLK_SRC_IN && clk_q;
            lock_oe_n_q <= asleep || !lken_q;
            lock_q      <= lock_sts_q;
        end
    end

    // Radio controls.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            blk_q     <= rcm_blocks(RCM_GEN_RST[RCM_MODE_LSB+:3]);
            tone_q    <= RCM_DEV_RST;
            iq_pos_q  <= 1'b0;
            pa_on_q   <= 1'b0;
            fifo_en_q <= 1'b0;
        end else begin
            blk_q     <= rcm_blocks(mode_raw);
            tone_q    <= dev_q;
            iq_pos_q  <= ook ? 1'b1 : tx_bit;
            pa_on_q   <= in_tx && (!ook || tx_bit);
            fifo_en_q <= !cont;
        end
    end

    assign PRDATA_OUT       = rdata_q;
    assign PREADY_OUT       = ready_q;
    assign PSLVERR_OUT      = err_q;
    assign SDO_OUT          = sdo_q;
    assign SDO_OE_N_OUT     = sdo_oe_n_q;
    assign CFG_ACT_OUT      = cfg_act_q;
    assign DAT_ACT_OUT      = dat_act_q;
    assign EVT0_OUT         = evt0_q;
    assign EVT0_OE_N_OUT    = evt0_oe_n_q;
    assign EVT1_OUT         = evt1_q;
    assign EVT1_OE_N_OUT    = evt1_oe_n_q;
    assign DATA_OUT         = data_q;
    assign DATA_OE_N_OUT    = data_oe_n_q;
    assign HCLK_OUT         = hclk_q;
    assign HCLK_OE_N_OUT    = hclk_oe_n_q;
    assign LOCK_OUT         = lock_q;
    assign LOCK_OE_N_OUT    = lock_oe_n_q;
    assign BLK_EN_OUT       = blk_q;
    assign TONE_DEV_OUT     = tone_q;
    assign IQ_PHASE_POS_OUT = iq_pos_q;
    assign PA_ON_OUT        = pa_on_q;
    assign FIFO_PATH_EN_OUT = fifo_en_q;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);

    a_sdo_float: assert property (CFG_SEL_N_IN && DAT_SEL_N_IN |=> SDO_OE_N_OUT)
        else $error("serial output driven with no select");
    a_cfg_priority: assert property (!CFG_SEL_N_IN |=>
        CFG_ACT_OUT && !DAT_ACT_OUT && !SDO_OE_N_OUT && SDO_OUT == $past(SO_CFG_IN))
        else $error("configuration select lost priority");
    a_sleep_float: assert property (asleep |=>
        EVT0_OE_N_OUT && EVT1_OE_N_OUT && HCLK_OE_N_OUT && LOCK_OE_N_OUT)
        else $error("pin driven in sleep");
    a_evt_drive: assert property (((mode == RCM_STBY) || (mode == RCM_SYNTH)) && cont
        ##0 !cfg_rise |=> EVT0_OE_N_OUT && EVT1_OE_N_OUT ##1 EVT0_OE_N_OUT)
        else $error("event line driven in continuous standby");
    a_data_dir: assert property (1'b1 |=> DATA_OE_N_OUT == ($past(mode) != RCM_RX))
        else $error("data pin direction wrong");
    a_lock_pin: assert property (!asleep && !lken_q |=> LOCK_OE_N_OUT)
        else $error("lock pin driven while disabled");
    a_lock_sticky: assert property (lock_sts_q && !lock_clr |=> lock_sts_q)
        else $error("lock flag dropped without clear");
    a_commit_edge: assert property (!cfg_rise |=> $stable(gen_q) && $stable(dev_q))
        else $error("configuration changed without select release");
    a_mode_legal: assert property (mode_raw <= RCM_TX)
        else $error("reserved mode entered");
    a_fsk_phase: assert property (!ook |=> IQ_PHASE_POS_OUT == $past(tx_bit))
        else $error("FSK phase does not follow data");
    a_ook_amp: assert property (in_tx && ook |=>
        PA_ON_OUT == $past(tx_bit) && IQ_PHASE_POS_OUT)
        else $error("OOK amplifier does not follow data");
    a_tone_dev: assert property (1'b1 |=> TONE_DEV_OUT == $past(dev_q))
        else $error("tone frequency not from deviation");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held for two cycles");

    c_enter_rx: cover property (cfg_rise && mode_new == RCM_RX ##1 mode == RCM_RX);
    c_both_sel: cover property (!CFG_SEL_N_IN && !DAT_SEL_N_IN);
    c_ook_tx: cover property (in_tx && ook && tx_bit ##1 in_tx && !tx_bit);
    c_lock_clr: cover property (lock_sts_q && lock_clr && !PLL_LOCK_IN ##1 !lock_sts_q);

endmodule : rcm_mode_ctrl

// File: verification/rcm_host_model.sv
// Host side model: drives both selects and the shared data pin.
// Assumes the bench calls its tasks and the device drives the pin only in receive.
`timescale 1ns/100ps
module rcm_host_model (
    // Clock
    input  wire logic clk_in,
    // Device side of the data pin
    input  wire logic dev_data_in,
    input  wire logic dev_oe_n_in,
    input  wire logic host_bit_in,
    // Host pins
    output logic      cfg_sel_n_out,
    output logic      dat_sel_n_out,
    output logic      data_pin_out
);
    // The pin never floats: device level while it drives, host level otherwise.
    assign data_pin_out = dev_oe_n_in ? host_bit_in : dev_data_in;
    initial begin
        cfg_sel_n_out = 1'b1;
        dat_sel_n_out = 1'b1;
    end
    task automatic sel(input logic c, input logic d);
        @(posedge clk_in);
        cfg_sel_n_out <= c;
        dat_sel_n_out <= d;
    endtask : sel
    // A low pulse on the config select commits staged settings as it rises.
    task automatic commit();
        sel(1'b0, 1'b1);
        sel(1'b1, 1'b1);
        repeat (3) @(posedge clk_in);
    endtask : commit
endmodule : rcm_host_model

// File: verification/tb.sv
// Self-checking bench for the chip mode and pin controller.
// Assumes the APB slave answers within sixteen access cycles and outputs lag one cycle.
`timescale 1ns/100ps
module tb
    import rcm_pkg::*;
;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        so_c = 1'b1, so_d = 1'b0, demod = 1'b0, txsr = 1'b0, hsrc = 1'b1;
    logic        synth_lock_pin = 1'b0, hbit = 1'b0;
    logic [1:0]  esrc = 2'h0;
    logic        cfg_n, dat_n, data_pin, sdo, sdo_oe_n, cfg_act, dat_act;
    logic        e0, e0_oe_n, e1, e1_oe_n, dout, doe_n, hclk, hclk_oe_n, lk, lk_oe_n;
    logic [7:0]  tone;
    logic        iqp, pa, fifo;
    logic [3:0]  tbl [4] = '{4'h5, 4'h5, 4'h2, 4'h8};
    rcm_blk_en_s blk;
    int          errors = 0, compares = 0;
    always #10 clk = ~clk;

    rcm_host_model host (.clk_in(clk), .dev_data_in(dout), .dev_oe_n_in(doe_n),
        .host_bit_in(hbit), .cfg_sel_n_out(cfg_n), .dat_sel_n_out(dat_n),
        .data_pin_out(data_pin));
    rcm_mode_ctrl dut (.CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CFG_SEL_N_IN(cfg_n),
        .DAT_SEL_N_IN(dat_n), .SO_CFG_IN(so_c), .SO_DAT_IN(so_d), .SDO_OUT(sdo),
        .SDO_OE_N_OUT(sdo_oe_n), .CFG_ACT_OUT(cfg_act), .DAT_ACT_OUT(dat_act),
        .EVT_SRC_IN(esrc), .EVT0_OUT(e0), .EVT0_OE_N_OUT(e0_oe_n), .EVT1_OUT(e1),
        .EVT1_OE_N_OUT(e1_oe_n), .DATA_IN(data_pin), .DEMOD_IN(demod),
        .TX_SR_BIT_IN(txsr), .DATA_OUT(dout), .DATA_OE_N_OUT(doe_n),
        .HCLK_SRC_IN(hsrc), .PLL_LOCK_IN(synth_lock_pin), .HCLK_OUT(hclk),
        .HCLK_OE_N_OUT(hclk_oe_n), .LOCK_OUT(lk), .LOCK_OE_N_OUT(lk_oe_n),
        .BLK_EN_OUT(blk), .TONE_DEV_OUT(tone), .IQ_PHASE_POS_OUT(iqp), .PA_ON_OUT(pa),
        .FIFO_PATH_EN_OUT(fifo));

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic gen(input logic [2:0] m, input logic ook, input logic cont);
        apb(1'b1, RCM_GEN_ADDR, {24'h0, m, ook, 1'b0, cont, 2'b00});
        host.commit();
        @(negedge clk);
    endtask : gen

    task automatic wt();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : wt

    // Enables per mode: spi and por always, then standby, synth, rx and tx sets.
    function automatic logic [17:0] exp_blk(input int m);
        logic [17:0] b;
        b = 18'h30000;
        if (m > 0) b[15:13] = 3'h7;
        if (m > 1) b[12:11] = 2'h3;
        if (m == 3) b[10:6] = 5'h1f;
        if (m == 4) b[5:0] = 6'h3f;
        return b;
    endfunction : exp_blk

    initial begin
        #1000000;
        errors++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        wt();
        chk(blk, exp_blk(1));
        chk({hclk_oe_n, hclk}, 2'b01);
        apb(1'b1, RCM_LOCK_ADDR, 32'h1);
        for (int m = 0; m < 5; m++) begin
            gen(m[2:0], 1'b0, 1'b0);
            chk(blk, exp_blk(m));
            chk(hclk_oe_n, m == 0);
            chk({e0_oe_n, e1_oe_n}, {2{m == 0}});
            chk(doe_n, m != 3);
            chk(lk_oe_n, m == 0);
            apb(1'b0, RCM_STAT_ADDR, 32'h0);
            chk(rd[2:0], m[2:0]);
        end
        apb(1'b1, RCM_GEN_ADDR, 32'h60);
        wt();
        chk(blk, exp_blk(4));
        gen(3'h5, 1'b0, 1'b0);
        chk(blk, exp_blk(4));
        apb(1'b1, RCM_DEV_ADDR, 32'ha5);
        apb(1'b1, RCM_CLK_ADDR, 32'h0);
        apb(1'b1, RCM_LOCK_ADDR, 32'h0);
        gen(3'h0, 1'b0, 1'b0);
        chk(tone, 8'ha5);
        gen(3'h1, 1'b0, 1'b0);
        chk(tone, 8'ha5);
        chk(hclk, 1'b0);
        chk(lk_oe_n, 1'b1);
        gen(3'h1, 1'b0, 1'b1);
        chk({e0_oe_n, fifo}, 2'b10);
        gen(3'h3, 1'b0, 1'b1);
        chk(e0_oe_n, 1'b0);
        for (int b = 1; b >= 0; b--) begin
            @(posedge clk) demod <= b[0];
            wt();
            chk(data_pin, b[0]);
        end
        gen(3'h3, 1'b0, 1'b0);
        chk(fifo, 1'b1);
        for (int k = 0; k < 4; k++) begin
            gen(3'h4, k[1], 1'b1);
            @(posedge clk) hbit <= k[0];
            wt();
            chk({iqp, pa}, k[1] ? {1'b1, k[0]} : {k[0], 1'b1});
        end
        for (int i = 0; i < 4; i++) begin
            host.sel(i[1], i[0] ~^ i[1]);
            wt();
            chk({sdo_oe_n, cfg_act, dat_act, sdo & ~sdo_oe_n}, tbl[i]);
        end
        apb(1'b1, RCM_EVT_ADDR, 32'h15);
        esrc <= 2'h1;
        gen(3'h1, 1'b0, 1'b0);
        chk({e0, e1}, 2'b11);
        apb(1'b1, RCM_EVT_ADDR, 32'h11);
        gen(3'h1, 1'b0, 1'b0);
        chk({e0, e1}, 2'b01);
        @(posedge clk) synth_lock_pin <= 1'b1;
        wt();
        chk(lk, 1'b1);
        @(posedge clk) synth_lock_pin <= 1'b0;
        apb(1'b0, RCM_LOCK_ADDR, 32'h0);
        apb(1'b0, RCM_LOCK_ADDR, 32'h0);
        chk(rd[1], 1'b1);
        chk(err, 1'b0);
        apb(1'b1, RCM_LOCK_ADDR, 32'h2);
        apb(1'b0, RCM_LOCK_ADDR, 32'h0);
        chk(rd[1], 1'b0);
        apb(1'b1, 8'h1c, 32'h1);
        chk(err, 1'b1);
        complete_run();
    end
endmodule : tb
